// ---- rtl/ssomux_top.sv ----
/*
 * Servo status output mux: builds the active-low status functions, routes
 * the selected ones to three output terminal pairs and offers the setting
 * registers, a live status view and interrupts over classic Wishbone.
 * Assumes pins are asynchronous levels, torque words and aux signals come
 * from logic on sys_clk, and a synchronous active-high reset.
 */
// Design decisions made here: register access over Wishbone and the register addresses.
`include "ssomux_map.svh"

module ssomux_top
    import ssomux_pkg::*;
#(
    parameter int TICK_CYCLES = `SSOMUX_TICK_CYCLES
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  ssomux_pins_s      pins_in,
    input  ssomux_aux_s       aux_in,
    input  ssomux_mode_e      ctrl_mode,
    input  wire logic [15:0]  torque_ref,
    input  wire logic [15:0]  motor_torque,
    output logic      [2:0]   term_out_n,
    output logic              irq_o
);

    localparam int NFUNC = 10;
    localparam int NPAIR = 3;
    localparam int DW    = `SSOMUX_DIGIT_W;
    localparam int PW    = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    ssomux_pins_s pins_s;

    ssomux_sync #(
        .W        ($bits(ssomux_pins_s))
    ) u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (pins_in),
        .sync_out (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register file state

    logic [15:0]      limit_ff;
    logic [15:0]      limit_eff_ff;
    logic [15:0]      assign_ff;
    logic [15:0]      tq_thr_ff;
    logic [15:0]      tq_time_ff;
    logic [15:0]      tq_lim_ff;
    logic [3:0]       irq_stat_ff;
    logic [3:0]       irq_mask_ff;
    logic             ack_ff;
    logic [31:0]      dat_ff;
    logic [15:0]      nxt_limit;
    logic [15:0]      nxt_limit_eff;
    logic [15:0]      nxt_assign;
    logic [15:0]      nxt_tq_thr;
    logic [15:0]      nxt_tq_time;
    logic [15:0]      nxt_tq_lim;
    logic [3:0]       nxt_irq_stat;
    logic [3:0]       nxt_irq_mask;
    logic             nxt_ack;
    logic [31:0]      nxt_dat;

    // Status function state
    logic [NFUNC-1:0] func_ff;
    logic [NFUNC-1:0] nxt_func;
    logic [NPAIR-1:0] term_n_ff;
    logic [NPAIR-1:0] nxt_term_n;
    logic [3:0]       events;

    // Torque detection delay state
    ssomux_td_e       td_state_ff;
    ssomux_td_e       nxt_td_state;
    logic [PW-1:0]    presc_ff;
    logic [PW-1:0]    nxt_presc;
    logic [15:0]      elapsed_ff;
    logic [15:0]      nxt_elapsed;

    ////////////////////////////////////////////////////////////////////////////
    // Bus helpers

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction

    logic bus_req;
    logic bus_wr;

    // A request is taken once; ack follows one cycle later
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign bus_wr  = bus_req & wb_we_i;

    ////////////////////////////////////////////////////////////////////////////
    // Status function evaluation

    logic fwd_active;
    logic rev_active;
    logic torque_over;
    logic mode_ok;

    always_comb begin
        // Prohibit inputs masked by the applied limit-disable digits
        fwd_active  = pins_s.fwd_prohibit_in &
                      (limit_eff_ff[`SSOMUX_LIM_FWD_LSB +: DW] != `SSOMUX_DIGIT_ON);
        rev_active  = pins_s.rev_prohibit_in &
                      (limit_eff_ff[`SSOMUX_LIM_REV_LSB +: DW] != `SSOMUX_DIGIT_ON);
        mode_ok     = (ctrl_mode != SSOMUX_MODE_OTHER);
        torque_over = (motor_torque > tq_thr_ff);
        nxt_func    = '0;
        // Function bits are ON-high, indexed by selection code
        nxt_func[0] = (ctrl_mode == SSOMUX_MODE_POSITION) ? aux_in.in_position : aux_in.speed_match;
        nxt_func[1] = aux_in.rotating;
        nxt_func[2] = pins_s.servo_on_cmd & pins_s.prep_done &
                      ~pins_s.alarm_active & pins_s.main_power_on;
        nxt_func[3] = mode_ok & (torque_ref > tq_lim_ff);
        nxt_func[4] = aux_in.brake_release;
        nxt_func[5] = pins_s.index_at_pos;
        nxt_func[6] = ~(fwd_active | rev_active);
        nxt_func[7] = pins_s.servo_on_cmd & pins_s.windings_excited;
        nxt_func[8] = aux_in.home_done;
        nxt_func[9] = (nxt_td_state == SSOMUX_TD_ON);
    end

    // Torque detection: ON only after the level persists for the set time
    always_comb begin
        nxt_td_state = td_state_ff;
        nxt_presc    = presc_ff;
        nxt_elapsed  = elapsed_ff;
        case (td_state_ff)
            SSOMUX_TD_IDLE: begin
                nxt_presc   = '0;
                nxt_elapsed = '0;
                if (torque_over) begin
                    nxt_td_state = (tq_time_ff == 16'h0000) ? SSOMUX_TD_ON : SSOMUX_TD_WAIT;
                end
            end
            SSOMUX_TD_WAIT: begin
                if (!torque_over) begin
                    nxt_td_state = SSOMUX_TD_IDLE;
                end else if (presc_ff == TICK_LAST) begin
                    nxt_presc   = '0;
                    nxt_elapsed = elapsed_ff + 16'h0001;
                    if (nxt_elapsed >= tq_time_ff) begin
                        nxt_td_state = SSOMUX_TD_ON;
                    end
                end else begin
                    nxt_presc = presc_ff + PW'(1);
                end
            end
            SSOMUX_TD_ON: begin
                if (!torque_over) begin
                    nxt_td_state = SSOMUX_TD_IDLE;
                end
            end
            default: begin
                nxt_td_state = SSOMUX_TD_IDLE;
            end
        endcase
    end

    // Register the torque detection state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            td_state_ff <= SSOMUX_TD_IDLE;
            presc_ff    <= '0;
            elapsed_ff  <= '0;
        end else begin
            td_state_ff <= nxt_td_state;
            presc_ff    <= nxt_presc;
            elapsed_ff  <= nxt_elapsed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Terminal routing, one selector per pair

    generate
        for (genvar p = 0; p < NPAIR; p++) begin : g_pair
            logic [DW-1:0] code;
            assign code = assign_ff[p*DW +: DW];
            // Active-low terminal, OFF for codes out of range
            assign nxt_term_n[p] = (code <= `SSOMUX_MAX_CODE) ?
                                   ~nxt_func[code] : 1'b1;
        end
    endgenerate

    // Events for the interrupt status
    always_comb begin
        events = '0;
        events[`SSOMUX_IRQ_READY_LOST] = func_ff[2] & ~nxt_func[2];
        events[`SSOMUX_IRQ_TRAV_IN]    = func_ff[6] & ~nxt_func[6];
        events[`SSOMUX_IRQ_TLIM_ON]    = ~func_ff[3] & nxt_func[3];
        events[`SSOMUX_IRQ_TDET_ON]    = ~func_ff[9] & nxt_func[9];
    end

    // Register functions and terminals on the drive clock
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            func_ff   <= '0;
            term_n_ff <= '1;
        end else begin
            func_ff   <= nxt_func;
            term_n_ff <= nxt_term_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, reads and interrupt status

    always_comb begin
        nxt_limit     = limit_ff;
        nxt_limit_eff = limit_eff_ff;
        nxt_assign    = assign_ff;
        nxt_tq_thr    = tq_thr_ff;
        nxt_tq_time   = tq_time_ff;
        nxt_tq_lim    = tq_lim_ff;
        nxt_irq_mask  = irq_mask_ff;
        nxt_irq_stat  = irq_stat_ff;
        nxt_ack       = bus_req;
        nxt_dat       = dat_ff;
        if (bus_wr) begin
            case (wb_adr_i)
                `SSOMUX_ADDR_LIMIT:    nxt_limit   = merge16(limit_ff, wb_dat_i, wb_sel_i);
                `SSOMUX_ADDR_ASSIGN:   nxt_assign  = merge16(assign_ff, wb_dat_i, wb_sel_i);
                `SSOMUX_ADDR_TQ_THR:   nxt_tq_thr  = merge16(tq_thr_ff, wb_dat_i, wb_sel_i);
                `SSOMUX_ADDR_TQ_TIME:  nxt_tq_time = merge16(tq_time_ff, wb_dat_i, wb_sel_i);
                `SSOMUX_ADDR_TQ_LIM:   nxt_tq_lim  = merge16(tq_lim_ff, wb_dat_i, wb_sel_i);
                `SSOMUX_ADDR_CTRL: begin
                    // Restart applies the stored limit-disable setting
                    if (wb_sel_i[0] && wb_dat_i[`SSOMUX_CTRL_RESTART]) begin
                        nxt_limit_eff = limit_ff;
                    end
                end
                `SSOMUX_ADDR_IRQ_STAT: begin
                    if (wb_sel_i[0]) begin
                        nxt_irq_stat = irq_stat_ff & ~wb_dat_i[3:0];
                    end
                end
                `SSOMUX_ADDR_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        nxt_irq_mask = wb_dat_i[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        nxt_irq_stat = nxt_irq_stat | events;
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `SSOMUX_ADDR_LIMIT:    nxt_dat = {16'h0000, limit_ff};
                `SSOMUX_ADDR_ASSIGN:   nxt_dat = {16'h0000, assign_ff};
                `SSOMUX_ADDR_TQ_THR:   nxt_dat = {16'h0000, tq_thr_ff};
                `SSOMUX_ADDR_TQ_TIME:  nxt_dat = {16'h0000, tq_time_ff};
                `SSOMUX_ADDR_TQ_LIM:   nxt_dat = {16'h0000, tq_lim_ff};
                `SSOMUX_ADDR_CTRL:     nxt_dat = {16'h0000, limit_eff_ff};
                `SSOMUX_ADDR_STATUS:   nxt_dat = {13'h0000, term_n_ff, 6'h00, func_ff};
                `SSOMUX_ADDR_IRQ_STAT: nxt_dat = {28'h0000000, irq_stat_ff};
                `SSOMUX_ADDR_IRQ_MASK: nxt_dat = {28'h0000000, irq_mask_ff};
                default:               nxt_dat = 32'h00000000;
            endcase
        end
    end

    // Register file flip-flops
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            limit_ff     <= `SSOMUX_RST_LIMIT;
            limit_eff_ff <= `SSOMUX_RST_LIMIT;
            assign_ff    <= `SSOMUX_RST_ASSIGN;
            tq_thr_ff    <= `SSOMUX_RST_TQ_THR;
            tq_time_ff   <= `SSOMUX_RST_TQ_TIME;
            tq_lim_ff    <= `SSOMUX_RST_TQ_LIM;
            irq_stat_ff  <= '0;
            irq_mask_ff  <= `SSOMUX_RST_IRQ_MASK;
            ack_ff       <= 1'b0;
            dat_ff       <= 32'h00000000;
        end else begin
            limit_ff     <= nxt_limit;
            limit_eff_ff <= nxt_limit_eff;
            assign_ff    <= nxt_assign;
            tq_thr_ff    <= nxt_tq_thr;
            tq_time_ff   <= nxt_tq_time;
            tq_lim_ff    <= nxt_tq_lim;
            irq_stat_ff  <= nxt_irq_stat;
            irq_mask_ff  <= nxt_irq_mask;
            ack_ff       <= nxt_ack;
            dat_ff       <= nxt_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_ack_o   = ack_ff;
    assign wb_dat_o   = dat_ff;
    assign term_out_n = term_n_ff;   // Active-low status terminals
    assign irq_o      = |(irq_stat_ff & irq_mask_ff);

endmodule // ssomux_top

// ---- rtl/ssomux_map.svh ----
/*
 * Register map, field positions, reset values and timing counts of the
 * servo status output mux.
 * Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
 */
// Overview of operation
// - Servo-ready goes low only after servo-on and finished preparation, else high.
// - Servo-ready also needs no active alarm and main power on.
// - Index-pulse output is low while the shaft sits at the encoder index.
// - Overtravel output is high while an enabled prohibit input is active, else low.
// - Limit-disable digit 1 equal 1 masks forward, digit 2 masks reverse prohibit.
// - With both prohibits disabled, overtravel output stays low permanently.
// - Excitation output is low while servo is enabled and windings energised.
// - In speed, torque, position modes, torque-limited is low when reference exceeds limit.
// - Torque-detection output is low once motor torque has exceeded the threshold for the set detection time.
// - Optional status functions appear only on a terminal pair selecting them.
// - Assignment digits 0, 1, 2 select functions of terminal pairs one, two, three.
// - Codes 0-9: in-pos (speed-match outside position mode), rotate, ready, tlim, brake, index, travel, excite, home, tdet.
// - Factory assignment routes servo-ready to the third terminal pair.
`ifndef SSOMUX_MAP_SVH
`define SSOMUX_MAP_SVH

// Byte offsets of the registers
`define SSOMUX_ADDR_LIMIT     8'h00
`define SSOMUX_ADDR_ASSIGN    8'h04
`define SSOMUX_ADDR_TQ_THR    8'h08
`define SSOMUX_ADDR_TQ_TIME   8'h0c
`define SSOMUX_ADDR_TQ_LIM    8'h10
`define SSOMUX_ADDR_CTRL      8'h14
`define SSOMUX_ADDR_STATUS    8'h18
`define SSOMUX_ADDR_IRQ_STAT  8'h1c
`define SSOMUX_ADDR_IRQ_MASK  8'h20

// Field positions
`define SSOMUX_DIGIT_W        4
`define SSOMUX_LIM_FWD_LSB    4
`define SSOMUX_LIM_REV_LSB    8
`define SSOMUX_DIGIT_ON       4'h1
`define SSOMUX_CTRL_RESTART   0
`define SSOMUX_STAT_TERM_LSB  16
`define SSOMUX_IRQ_READY_LOST 0
`define SSOMUX_IRQ_TRAV_IN    1
`define SSOMUX_IRQ_TLIM_ON    2
`define SSOMUX_IRQ_TDET_ON    3
`define SSOMUX_MAX_CODE       4'h9

// Reset values
`define SSOMUX_RST_LIMIT      16'h0000
`define SSOMUX_RST_ASSIGN     16'h0210
`define SSOMUX_RST_TQ_THR     16'h0064
`define SSOMUX_RST_TQ_TIME    16'h000a
`define SSOMUX_RST_TQ_LIM     16'h012c
`define SSOMUX_RST_IRQ_MASK   4'h0

// Timing: detection time unit is one millisecond
`define SSOMUX_CLK_KHZ        40000
`define SSOMUX_TICK_TIME_MS   1
`define SSOMUX_TICK_CYCLES    (`SSOMUX_TICK_TIME_MS * `SSOMUX_CLK_KHZ)

`endif

// ---- rtl/ssomux_pkg.sv ----
/*
 * Types of the servo status output mux: control modes,
 * pin and helper-signal bundles, torque detection states.
 * Assumes nothing beyond the map header.
 */
package ssomux_pkg;

    // Control mode reported by the drive
    typedef enum logic [1:0] {
        SSOMUX_MODE_SPEED    = 2'b00,
        SSOMUX_MODE_TORQUE   = 2'b01,
        SSOMUX_MODE_POSITION = 2'b10,
        SSOMUX_MODE_OTHER    = 2'b11
    } ssomux_mode_e;

    // Torque detection delay states
    typedef enum logic [1:0] {
        SSOMUX_TD_IDLE = 2'b00,
        SSOMUX_TD_WAIT = 2'b01,
        SSOMUX_TD_ON   = 2'b10
    } ssomux_td_e;

    // Conditions arriving on pins from outside the clock domain
    typedef struct packed {
        logic servo_on_cmd;
        logic prep_done;
        logic alarm_active;
        logic main_power_on;
        logic index_at_pos;
        logic windings_excited;
        logic fwd_prohibit_in;
        logic rev_prohibit_in;
    } ssomux_pins_s;

    // Conditions from drive logic on the same clock
    typedef struct packed {
        logic in_position;
        logic speed_match;
        logic rotating;
        logic brake_release;
        logic home_done;
    } ssomux_aux_s;

endpackage : ssomux_pkg

// ---- rtl/ssomux_sync.sv ----
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is an unrelated level; not for multi-bit words.
 */
module ssomux_sync
    import ssomux_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] stage_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_stage;

    // First stage feeds only the second
    always_comb begin
        nxt_meta  = async_in;
        nxt_stage = meta_ff;
    end

    // Register both stages
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_ff  <= '0;
            stage_ff <= '0;
        end else begin
            meta_ff  <= nxt_meta;
            stage_ff <= nxt_stage;
        end
    end

    assign sync_out = stage_ff;

endmodule // ssomux_sync

// ---- dv/ssomux_monitor.sv ----
/* Port checker of the status output mux: bus handshake, reset state, routing.
   Assumes full 16-bit register writes and that it is bound to ssomux_top. */
`include "ssomux_map.svh"
module ssomux_monitor
    import ssomux_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         sys_rst,
    input wire logic         wb_cyc_i,
    input wire logic         wb_stb_i,
    input wire logic         wb_we_i,
    input wire logic [7:0]   wb_adr_i,
    input wire logic [3:0]   wb_sel_i,
    input wire logic [31:0]  wb_dat_i,
    input wire logic [31:0]  wb_dat_o,
    input wire logic         wb_ack_o,
    input ssomux_pins_s      pins_in,
    input ssomux_aux_s       aux_in,
    input ssomux_mode_e      ctrl_mode,
    input wire logic [15:0]  torque_ref,
    input wire logic [15:0]  motor_torque,
    input wire logic [2:0]   term_out_n,
    input wire logic         irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic         take, ok;
    logic [2:0]   quiet_ff;
    logic [15:0]  lim_ff, asg_ff, thr_ff, tlm_ff, app_ff, tr1_ff, mt1_ff, fn;
    ssomux_pins_s p1_ff, p2_ff, p3_ff;
    ssomux_mode_e m1_ff;

    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ok   = quiet_ff == 3'd4;

    ////////////////////////////////////////////////////////////////////////
    // Shadow settings, input delay to match the outputs, settle counter
    always_ff @(posedge sys_clk) begin
        p1_ff  <= pins_in;
        p2_ff  <= p1_ff;
        p3_ff  <= p2_ff;
        m1_ff  <= ctrl_mode;
        tr1_ff <= torque_ref;
        mt1_ff <= motor_torque;
        if (sys_rst) begin
            quiet_ff <= 3'd0;
            lim_ff   <= `SSOMUX_RST_LIMIT;
            asg_ff   <= `SSOMUX_RST_ASSIGN;
            thr_ff   <= `SSOMUX_RST_TQ_THR;
            tlm_ff   <= `SSOMUX_RST_TQ_LIM;
            app_ff   <= 16'h0000;
        end else begin
            quiet_ff <= (take && wb_we_i) ? 3'd0 : quiet_ff + {2'd0, quiet_ff != 3'd4};
            if (take && wb_we_i) begin
                case (wb_adr_i)
                    `SSOMUX_ADDR_LIMIT:  lim_ff <= wb_dat_i[15:0];
                    `SSOMUX_ADDR_ASSIGN: asg_ff <= wb_dat_i[15:0];
                    `SSOMUX_ADDR_TQ_THR: thr_ff <= wb_dat_i[15:0];
                    `SSOMUX_ADDR_TQ_LIM: tlm_ff <= wb_dat_i[15:0];
                    `SSOMUX_ADDR_CTRL:   app_ff <= wb_dat_i[0] ? lim_ff : app_ff;
                    default:             app_ff <= app_ff;
                endcase
            end
        end
    end

    // Expected ON state of the ready, tlim, index, travel and excite functions by code
    always_comb begin
        fn    = 16'h0000;
        fn[2] = p3_ff.servo_on_cmd & p3_ff.prep_done & !p3_ff.alarm_active & p3_ff.main_power_on;
        fn[3] = m1_ff != SSOMUX_MODE_OTHER && tr1_ff > tlm_ff;
        fn[5] = p3_ff.index_at_pos;
        fn[6] = !(p3_ff.fwd_prohibit_in && app_ff[7:4] != 4'h1) && !(p3_ff.rev_prohibit_in && app_ff[11:8] != 4'h1);
        fn[7] = p3_ff.servo_on_cmd & p3_ff.windings_excited;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer and reset state
    ack_answer_a: assert property (take |=> wb_ack_o)
        else $error("No ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");
    rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> term_out_n == 3'b111 && !wb_ack_o && !irq_o)
        else $error("Outputs not idle after reset");

    // Per terminal pair routing
    for (genvar p = 0; p < 3; p++) begin : g_pair
        wire logic [3:0] c = asg_ff[4*p +: 4];
        ready_route_a: assert property (ok && c == 4'h2 |-> term_out_n[p] == !fn[2])
            else $error("Ready pair level wrong");
        tlim_route_a: assert property (ok && c == 4'h3 |-> term_out_n[p] == !fn[3])
            else $error("Torque limit pair level wrong");
        index_route_a: assert property (ok && c == 4'h5 |-> term_out_n[p] == !fn[5])
            else $error("Index pair level wrong");
        trv_route_a: assert property (ok && c == 4'h6 |-> term_out_n[p] == !fn[6])
            else $error("Overtravel pair level wrong");
        excite_route_a: assert property (ok && c == 4'h7 |-> term_out_n[p] == !fn[7])
            else $error("Excitation pair level wrong");
        tdet_off_a: assert property (ok && c == 4'h9 && mt1_ff <= thr_ff |-> term_out_n[p])
            else $error("Torque detect on below threshold");
        bad_code_a: assert property (ok && c > 4'h9 |-> term_out_n[p])
            else $error("Undefined code drives pair");
    end

    // Main scenarios reached
    cover property (take && wb_we_i && wb_adr_i == `SSOMUX_ADDR_CTRL);
    cover property (irq_o);
    cover property (term_out_n == 3'b000);
endmodule // ssomux_monitor

bind ssomux_top ssomux_monitor i_mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_in(pins_in), .aux_in(aux_in),
    .ctrl_mode(ctrl_mode), .torque_ref(torque_ref), .motor_torque(motor_torque),
    .term_out_n(term_out_n), .irq_o(irq_o)
);

// ---- dv/ssomux_host.sv ----
/* Host controller model: gates its motion reference on the overtravel terminal.
   Assumes active-low terminals and that TRV_PAIR carries the overtravel code. */
module ssomux_host
#(
    parameter int TRV_PAIR = 0
) (
    input  wire logic       sys_clk,
    input  wire logic [2:0] term_out_n,
    output logic            ref_en_ff
);
    timeunit 1ns;
    timeprecision 100ps;

    // Send reference only while overtravel reads ON
    always_ff @(posedge sys_clk) begin
        ref_en_ff <= !term_out_n[TRV_PAIR];
    end
endmodule // ssomux_host

// ---- dv/servo_status_output_mux_tb.sv ----
/* Bench of the status output mux: Wishbone tasks and status scenarios.
   Assumes a 4-cycle millisecond tick and the host model on pair 1. */
`include "ssomux_map.svh"
module servo_status_output_mux_tb
    import ssomux_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic         sys_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]   wb_adr_i = 8'h00;
    logic [3:0]   wb_sel_i = 4'h0;
    logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, q;
    logic         wb_ack_o, irq_o, ref_en;
    logic [2:0]   term_out_n;
    logic [15:0]  torque_ref = 16'h0, motor_torque = 16'h0;
    ssomux_pins_s pins_in = '0;
    ssomux_aux_s  aux_in = '0;
    ssomux_mode_e ctrl_mode = SSOMUX_MODE_POSITION;
    int           n_mismatch = 0, tests_run = 0;
    logic [7:0]   ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
    logic [31:0]  rv [8] = '{32'h0, 32'h210, 32'h64, 32'ha, 32'h12c, 32'h0, 32'h0, 32'h0};
    logic [7:0]   pv [4] = '{8'hd0, 8'hf0, 8'h90, 8'hc0};
    logic [2:0]   tv [4] = '{3'b011, 3'b111, 3'b111, 3'b111};

    always #12.5 sys_clk = ~sys_clk;

    ssomux_top #(.TICK_CYCLES(4)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_in(pins_in), .aux_in(aux_in),
        .ctrl_mode(ctrl_mode), .torque_ref(torque_ref), .motor_torque(motor_torque),
        .term_out_n(term_out_n), .irq_o(irq_o));
    ssomux_host #(.TRV_PAIR(0)) i_host (.sys_clk(sys_clk), .term_out_n(term_out_n), .ref_en_ff(ref_en));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // One classic Wishbone cycle; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Drive the status sources; one torque word serves both comparisons
    task automatic env(input logic [7:0] p, input logic [4:0] x, input logic [15:0] t);
        @(posedge sys_clk);
        pins_in      <= p;
        aux_in       <= x;
        torque_ref   <= t;
        motor_torque <= t;
    endtask

    // Overtravel on all pairs under a limit setting
    task automatic trv_step(input logic [15:0] lim, input logic rs, input logic [7:0] p, input logic on);
        bus(1'b1, `SSOMUX_ADDR_LIMIT, lim);
        if (rs) bus(1'b1, `SSOMUX_ADDR_CTRL, 16'h0001);
        env(p, 5'h00, 16'h0064);
        w(6);
        chk({29'h0, term_out_n}, {29'h0, {3{!on}}});
        chk({31'h0, ref_en}, {31'h0, on});
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        w(20);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, ra[i], 16'h0000);
            chk(q, rv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            env(pv[i], 5'h00, 16'h0064);
            w(5);
            chk({29'h0, term_out_n}, {29'h0, tv[i]});
        end
        bus(1'b1, `SSOMUX_ADDR_TQ_TIME, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            env(j ? 8'h03 : 8'hdc, j ? 5'h00 : 5'h0f, j ? 16'h0064 : 16'h012d);
            ctrl_mode <= j ? SSOMUX_MODE_POSITION : SSOMUX_MODE_SPEED;
            for (int k = 0; k < 16; k++) begin
                bus(1'b1, `SSOMUX_ADDR_ASSIGN, {4'h0, {3{k[3:0]}}});
                w(3);
                chk({29'h0, term_out_n}, (j || k > 9) ? 32'h7 : 32'h0);
            end
        end
        env(8'hd3, 5'h00, 16'h012d);
        bus(1'b1, `SSOMUX_ADDR_ASSIGN, 16'h0352);
        ctrl_mode <= SSOMUX_MODE_OTHER;
        w(4);
        chk({29'h0, term_out_n}, 32'h6);
        bus(1'b1, `SSOMUX_ADDR_ASSIGN, 16'h0666);
        trv_step(16'h0110, 1'b0, 8'h03, 1'b0);
        trv_step(16'h0110, 1'b1, 8'h03, 1'b1);
        trv_step(16'h0010, 1'b1, 8'h02, 1'b1);
        trv_step(16'h0010, 1'b0, 8'h01, 1'b0);
        trv_step(16'h0020, 1'b1, 8'h02, 1'b0);
        trv_step(16'h0110, 1'b1, 8'h03, 1'b1);
        // Overtravel entry sets a sticky flag; mask then clear
        bus(1'b1, `SSOMUX_ADDR_IRQ_STAT, 16'h000f);
        trv_step(16'h0000, 1'b1, 8'h03, 1'b0);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, `SSOMUX_ADDR_IRQ_MASK, 16'h0002);
        w(1);
        chk({31'h0, irq_o}, 32'h1);
        bus(1'b0, `SSOMUX_ADDR_IRQ_STAT, 16'h0000);
        chk(q & 32'h2, 32'h2);
        bus(1'b1, `SSOMUX_ADDR_IRQ_STAT, 16'h0002);
        w(1);
        chk({31'h0, irq_o}, 32'h0);
        // Torque detection with a three-tick delay
        bus(1'b1, `SSOMUX_ADDR_ASSIGN, 16'h0999);
        bus(1'b1, `SSOMUX_ADDR_TQ_TIME, 16'h0003);
        env(8'h00, 5'h00, 16'h0065);
        w(8);
        chk({29'h0, term_out_n}, 32'h7);
        w(12);
        chk({29'h0, term_out_n}, 32'h0);
        env(8'h00, 5'h00, 16'h0064);
        w(3);
        chk({29'h0, term_out_n}, 32'h7);
        results;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        results;
    end
endmodule // servo_status_output_mux_tb
